// File: scc_host.sv
// Host model driving the serial register port of the configuration block.
// Assumes the system clock of the bench; link clock is 32 ns and idles low.
module scc_host (
  input  wire logic clk,  // System clock
  input  wire logic sdo,  // Serial data from the device
  output logic      cs_n, // Chip select, active low
  output logic      sclk, // Serial clock, idle low
  output logic      sdi   // Serial data to the device
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels at time zero
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // Half a link period, eight system clocks per period
  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half

  // One 24-clock frame; the answer is taken just before rises 17 to 24
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] c;
    c = {a, w, d};
    cs_n = 1'b0;
    half();
    for (int i = 0; i < 24; i++) begin
      sdi = (i < 16) ? c[15 - i] : ~sdi;
      half();
      if (i >= 16) q[23 - i] = sdo;
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    sdi = ~sdi; // Released line no longer shows its last value
    half();
  endtask : xfer
endmodule : scc_host

// File: scc_pkg.sv
// Constants shared by the scan channel configuration block.
// Assumes a serial register frame of 16 command bits and 8 answer bits.
package scc_pkg;

  // Register addresses carried in frame bits 15-9
  localparam logic [6:0] ADDR_SCAN_CHANNEL_ENABLE = 7'h01;
  localparam logic [6:0] ADDR_CHANNEL_POWER_DOWN  = 7'h02;
  localparam logic [6:0] ADDR_FEATURE_SELECT      = 7'h03;

  // Reset values
  localparam logic [7:0] RST_SCAN_CHANNEL_ENABLE = 8'hff;
  localparam logic [7:0] RST_CHANNEL_POWER_DOWN  = 8'h00;
  localparam logic [7:0] RST_FEATURE_SELECT      = 8'h00;

  // Feature select field positions
  localparam int FEAT_DEV_MSB = 7;
  localparam int FEAT_DEV_LSB = 6;
  localparam int FEAT_FMT_MSB = 2;
  localparam int FEAT_FMT_LSB = 0;
  localparam logic [7:0] FEAT_WRITABLE_MASK = 8'hc7;

  // Frame layout
  localparam int FRAME_ADDR_MSB = 15;
  localparam int FRAME_ADDR_LSB = 9;
  localparam int FRAME_WR_BIT   = 8;
  localparam logic [4:0] CMD_BITS     = 5'h10;
  localparam logic [4:0] ANSWER_END   = 5'h18;

  // Output word formats
  localparam logic [2:0] FMT_RESULT_ONLY = 3'h0;
  localparam logic [2:0] FMT_WITH_CHAN   = 3'h1;
  localparam logic [2:0] FMT_WITH_DEV    = 3'h2;
  localparam logic [2:0] FMT_WITH_RANGE  = 3'h3;

endpackage : scc_pkg

// File: scc_regs.sv
// Scan channel configuration registers behind the serial register port.
// Assumes pins cs_n, sclk and sdi arrive unsynchronised; sclk is far slower than clk.
// Behaviour
// - Scan enable bit n includes channel n in the automatic scan.
// - Scan enable resets to all ones.
// - With no channel eligible, channel 0 is converted.
// - Four-channel build ignores writes to upper channel bits.
// - Four-channel build reads upper channel bits as ones.
// - Power-down bit n turns off front-end n and drops it from scan.
// - Power-down register resets to all zeros.
// - All front-ends off gives invalid results, no flag raised.
// - Feature bits 7-6 hold read/write device ID, reset zero.
// - Feature bits 5-3 read zero; host writes zeros.
// - Feature bits 2-0 select output format, reset zero.
// - Automatic scan steps ascending, one channel per conversion.
// - Frame: address bits 15-9, write flag bit 8, data, 24 clocks.
// - Read data leaves MSB first from the 16th falling edge.
// - Format codes append channel, device ID, range; rest low.
module scc_regs #(
  parameter int NUM_CH = 8
) (
  input  wire logic        clk,             // System clock, 250 MHz
  input  wire logic        resetn,          // Asynchronous reset, active low
  input  wire logic        ce,              // Clock enable, freezes state when low
  input  wire logic        cs_n,            // Serial chip select pin, active low
  input  wire logic        sclk,            // Serial clock pin
  input  wire logic        sdi,             // Serial data in pin
  output logic             sdo,             // Serial data out pin
  input  wire logic        manual_single_channel_mode, // Manual mode select
  input  wire logic [2:0]  manual_channel,  // Channel used in manual mode
  input  wire logic        conv_start,      // Pulse: a conversion begins
  input  wire logic [15:0] conv_result,     // Conversion result
  input  wire logic [2:0]  range_bits,      // Range code of the channel
  output logic [7:0]       chan_frontend_off, // Front-end power-down per channel
  output logic [1:0]       device_id,       // Daisy-chain identifier
  output logic [2:0]       output_word_format, // Output format code
  output logic [2:0]       active_channel,  // Channel now converted
  output logic [24:0]      result_word      // Composed output word
);

  localparam logic [7:0] PRESENT = 8'((9'h001 << NUM_CH) - 9'h001);

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [1:0]  cs_sync;
  logic [2:0]  sclk_sync;
  logic [1:0]  sdi_sync;
  logic [7:0]  scan_channel_enable;
  logic [7:0]  channel_power_down;
  logic [7:0]  feature_select;
  logic [15:0] cmd_shift;
  logic [4:0]  rise_cnt;
  logic [4:0]  fall_cnt;
  logic [7:0]  out_shift;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        in_frame;
  logic [15:0] next_cmd;
  logic        cmd_done;
  logic [7:0]  wdata;
  logic [7:0]  answer;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync   <= 2'h3;
      sclk_sync <= 3'h0;
      sdi_sync  <= 2'h0;
    end else if (ce) begin
      cs_sync   <= {cs_sync[0], cs_n};
      sclk_sync <= {sclk_sync[1:0], sclk};
      sdi_sync  <= {sdi_sync[0], sdi};
    end
  end

  assign in_frame  = ~cs_sync[1];
  assign sclk_rise = in_frame && sclk_sync[1] && !sclk_sync[2];
  assign sclk_fall = in_frame && !sclk_sync[1] && sclk_sync[2];
  assign next_cmd  = {cmd_shift[14:0], sdi_sync[1]};
  assign cmd_done  = sclk_rise && (rise_cnt == scc_pkg::CMD_BITS - 5'h01);

  // Command shift and edge counts, restarted by each frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_shift <= 16'h0000;
      rise_cnt  <= 5'h00;
      fall_cnt  <= 5'h00;
    end else if (ce) begin
      if (!in_frame) begin
        rise_cnt <= 5'h00;
        fall_cnt <= 5'h00;
      end else begin
        if (sclk_rise && rise_cnt != scc_pkg::ANSWER_END) begin
          cmd_shift <= next_cmd;
          rise_cnt  <= rise_cnt + 5'h01;
        end
        if (sclk_fall && fall_cnt != scc_pkg::ANSWER_END) begin
          fall_cnt <= fall_cnt + 5'h01;
        end
      end
    end
  end

  // Stored view of a register, upper channels read as ones
  function automatic logic [7:0] reg_view(input logic [6:0] addr, input logic [7:0] en,
                                          input logic [7:0] pd, input logic [7:0] feat);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      scc_pkg::ADDR_SCAN_CHANNEL_ENABLE: v = en | ~PRESENT;
      scc_pkg::ADDR_CHANNEL_POWER_DOWN:  v = pd | ~PRESENT;
      scc_pkg::ADDR_FEATURE_SELECT:      v = feat & scc_pkg::FEAT_WRITABLE_MASK;
      default:                           v = 8'h00;
    endcase
    return v;
  endfunction : reg_view

  assign wdata = next_cmd[7:0];

  // Answer is the addressed register, new value after a write
  always_comb begin
    if (next_cmd[scc_pkg::FRAME_WR_BIT]) begin
      answer = reg_view(next_cmd[scc_pkg::FRAME_ADDR_MSB:scc_pkg::FRAME_ADDR_LSB],
                        wdata & PRESENT, wdata & PRESENT, wdata);
    end else begin
      answer = reg_view(next_cmd[scc_pkg::FRAME_ADDR_MSB:scc_pkg::FRAME_ADDR_LSB],
                        scan_channel_enable, channel_power_down, feature_select);
    end
  end

  // Register writes at the end of the command word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_channel_enable <= scc_pkg::RST_SCAN_CHANNEL_ENABLE;
      channel_power_down  <= scc_pkg::RST_CHANNEL_POWER_DOWN;
      feature_select      <= scc_pkg::RST_FEATURE_SELECT;
    end else if (ce && cmd_done && next_cmd[scc_pkg::FRAME_WR_BIT]) begin
      unique case (next_cmd[scc_pkg::FRAME_ADDR_MSB:scc_pkg::FRAME_ADDR_LSB])
        scc_pkg::ADDR_SCAN_CHANNEL_ENABLE: scan_channel_enable <= wdata & PRESENT;
        scc_pkg::ADDR_CHANNEL_POWER_DOWN:  channel_power_down  <= wdata & PRESENT;
        scc_pkg::ADDR_FEATURE_SELECT:
          feature_select <= wdata & scc_pkg::FEAT_WRITABLE_MASK;
        default: ;
      endcase
    end
  end

  // Answer bits leave MSB first from the 16th falling edge, low otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_shift <= 8'h00;
      sdo       <= 1'b0;
    end else if (ce) begin
      if (!in_frame) begin
        sdo <= 1'b0;
      end else begin
        if (cmd_done) begin
          out_shift <= answer;
        end
        if (sclk_fall) begin
          if (fall_cnt >= scc_pkg::CMD_BITS - 5'h01 && fall_cnt < scc_pkg::ANSWER_END - 5'h01) begin
            sdo       <= out_shift[7];
            out_shift <= {out_shift[6:0], 1'b0};
          end else begin
            sdo <= 1'b0;
          end
        end
      end
    end
  end

  // Front-end control; all off is allowed and not flagged
  assign chan_frontend_off  = channel_power_down;
  assign device_id          = feature_select[scc_pkg::FEAT_DEV_MSB:scc_pkg::FEAT_DEV_LSB];
  assign output_word_format = feature_select[scc_pkg::FEAT_FMT_MSB:scc_pkg::FEAT_FMT_LSB];

  // Scan sequencer and output word
  scc_scan_seq #(
    .NUM_CH(NUM_CH)
  ) u_scan (
    .clk                        (clk),
    .rst_n                      (rst_n),
    .ce                         (ce),
    .scan_include               (scan_channel_enable),
    .frontend_off               (channel_power_down),
    .output_word_format         (output_word_format),
    .device_id                  (device_id),
    .manual_single_channel_mode (manual_single_channel_mode),
    .manual_channel             (manual_channel),
    .conv_start                 (conv_start),
    .conv_result                (conv_result),
    .range_bits                 (range_bits),
    .active_channel             (active_channel),
    .result_word                (result_word)
  );

endmodule : scc_regs

// File: scc_regs_chk_sva.sv
// Checker for the scan channel configuration registers.
// Bound to scc_regs; sees only its ports.
module scc_regs_chk (
  input wire logic        clk,                        // System clock
  input wire logic        resetn,                     // Reset, active low
  input wire logic        ce,                         // Clock enable
  input wire logic        cs_n,                       // Chip select
  input wire logic        sdo,                        // Serial data out
  input wire logic        manual_single_channel_mode, // Manual mode
  input wire logic [2:0]  manual_channel,             // Manual channel
  input wire logic        conv_start,                 // Conversion start
  input wire logic [15:0] conv_result,                // Result in
  input wire logic [2:0]  range_bits,                 // Range code in
  input wire logic [7:0]  chan_frontend_off,          // Power-down bits
  input wire logic [1:0]  device_id,                  // Device ID
  input wire logic [2:0]  output_word_format,         // Format code
  input wire logic [2:0]  active_channel,             // Channel converted
  input wire logic [24:0] result_word                 // Output word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rs;   // Follows the design's reset release
  logic [7:0] pd_q; // Power-down bits one cycle back
  // Checks wait until the synchronised reset is gone
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rs <= 3'h0;
    else rs <= {rs[1:0], 1'b1};
  end
  always_ff @(posedge clk) pd_q <= chan_frontend_off;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rs[2]);
  sequence s_auto; conv_start && ce && !manual_single_channel_mode; endsequence
  sequence s_man; conv_start && ce && manual_single_channel_mode; endsequence
  sequence s_idle; cs_n [*6]; endsequence
  AST_SDO_IDLE: assert property (s_idle |-> !sdo)
    else $error("sdo driven outside a frame");
  AST_CFG_HOLD: assert property (s_idle |=>
    $stable({chan_frontend_off, device_id, output_word_format}))
    else $error("configuration changed outside a frame");
  AST_PD_SKIP: assert property (s_auto |=> !pd_q[active_channel] || active_channel == 3'h0)
    else $error("powered-down channel scanned");
  AST_MANUAL: assert property (s_man |=> active_channel == $past(manual_channel))
    else $error("manual channel not taken");
  AST_CH_HOLD: assert property (!(conv_start && ce) |=> $stable(active_channel))
    else $error("channel moved without a conversion");
  AST_FREEZE: assert property (!ce |=> $stable(result_word))
    else $error("output word moved with clock enable low");
  AST_RESULT: assert property (ce |=> result_word[24:9] == $past(conv_result))
    else $error("result field wrong");
  AST_FMT0: assert property (ce && output_word_format == 3'h0 |=> result_word[8:0] == 9'h0)
    else $error("format zero trailing bits not low");
  AST_FMT_DEV: assert property (ce && output_word_format == 3'h2 |=>
    result_word[4:0] == {$past(device_id), 3'h0})
    else $error("device field wrong");
  AST_CHAN_MSB: assert property (ce |=> !result_word[8])
    else $error("channel field top bit set");
  AST_FMT_CHAN: assert property (ce && output_word_format == 3'h1 |=>
    result_word[8:0] == {1'b0, $past(active_channel), 5'h00})
    else $error("channel field wrong");
  AST_FMT_RNG: assert property (ce && output_word_format == 3'h3 |=>
    result_word[2:0] == $past(range_bits))
    else $error("range field wrong");
endmodule : scc_regs_chk

bind scc_regs scc_regs_chk u_chk (.clk, .resetn, .ce, .cs_n, .sdo, .manual_single_channel_mode,
  .manual_channel, .conv_start, .conv_result, .range_bits, .chan_frontend_off, .device_id,
  .output_word_format, .active_channel, .result_word);

// File: scc_scan_seq.sv
// Automatic ascending channel scan and output word composer.
// Assumes conv_start is a one-cycle pulse from logic on the same clock.
module scc_scan_seq #(
  parameter int NUM_CH = 8
) (
  input  wire logic        clk,             // System clock
  input  wire logic        rst_n,           // Synchronised reset, active low
  input  wire logic        ce,              // Clock enable
  input  wire logic [7:0]  scan_include,    // Stored scan enable bits
  input  wire logic [7:0]  frontend_off,    // Stored power-down bits
  input  wire logic [2:0]  output_word_format, // Output format code
  input  wire logic [1:0]  device_id,       // Daisy-chain identifier
  input  wire logic        manual_single_channel_mode, // Manual mode select
  input  wire logic [2:0]  manual_channel,  // Channel used in manual mode
  input  wire logic        conv_start,      // Pulse: a conversion begins
  input  wire logic [15:0] conv_result,     // Result of the last conversion
  input  wire logic [2:0]  range_bits,      // Range code of the channel
  output logic [2:0]       active_channel,  // Channel now converted
  output logic [24:0]      result_word      // Composed output word
);

  logic [7:0] eligible;
  logic [2:0] next_channel;

  // Channel takes part only if included, powered and present
  always_comb begin
    eligible = scan_include & ~frontend_off;
    for (int i = 0; i < 8; i++) begin
      if (i >= NUM_CH) eligible[i] = 1'b0;
    end
  end

  // Next higher eligible channel, wrapping to the lowest
  always_comb begin
    next_channel = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (eligible[i]) next_channel = 3'(i);
    end
    for (int i = 7; i >= 0; i--) begin
      if (eligible[i] && 3'(i) > active_channel) next_channel = 3'(i);
    end
  end

  // Step on each conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_channel <= 3'h0;
    end else if (ce && conv_start) begin
      if (manual_single_channel_mode) begin
        active_channel <= manual_channel;
      end else begin
        active_channel <= next_channel;
      end
    end
  end

  // Output word fields appended by format, unused bits low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_word <= 25'h0000000;
    end else if (ce) begin
      unique case (output_word_format)
        scc_pkg::FMT_WITH_CHAN:  result_word <= {conv_result, 1'b0, active_channel, 5'h00};
        scc_pkg::FMT_WITH_DEV:   result_word <= {conv_result, 1'b0, active_channel, device_id,
                                                 3'h0};
        scc_pkg::FMT_WITH_RANGE: result_word <= {conv_result, 1'b0, active_channel, device_id,
                                                 range_bits};
        default:                 result_word <= {conv_result, 9'h000};
      endcase
    end
  end

endmodule : scc_scan_seq

// File: tb.sv
// Self-checking bench for the scan channel configuration registers.
// Assumes scc_host as serial master; an eight- and a four-channel build share its pins.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] A_EN = scc_pkg::ADDR_SCAN_CHANNEL_ENABLE;
  localparam logic [6:0] A_PD = scc_pkg::ADDR_CHANNEL_POWER_DOWN;
  localparam logic [6:0] A_FT = scc_pkg::ADDR_FEATURE_SELECT;
  logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, sel4 = 1'b0, man = 1'b0, cst = 1'b0;
  logic cs_n, sclk, sdi, sdo8, sdo4;
  logic [2:0] mch = 3'h0, rng = 3'h0, ach, fmt, mc;
  logic [1:0] dev;
  logic [15:0] res = 16'h1414;
  logic [7:0] pd8, pd4, q, v, en, pd, lf = 8'h14;
  int error_cnt = 0, checks = 0, cyc = 0;
  always #2 clk = ~clk;
  scc_host host (.clk, .sdo(sel4 ? sdo4 : sdo8), .cs_n, .sclk, .sdi);
  scc_regs #(.NUM_CH(8)) DUT (.clk, .resetn, .ce, .cs_n, .sclk, .sdi, .sdo(sdo8),
    .manual_single_channel_mode(man), .manual_channel(mch), .conv_start(cst),
    .conv_result(res), .range_bits(rng), .chan_frontend_off(pd8), .device_id(dev),
    .output_word_format(fmt), .active_channel(ach), .result_word());
  scc_regs #(.NUM_CH(4)) DUT4 (.clk, .resetn, .ce, .cs_n, .sclk, .sdi, .sdo(sdo4),
    .manual_single_channel_mode(man), .manual_channel(mch), .conv_start(cst),
    .conv_result(res), .range_bits(rng), .chan_frontend_off(pd4), .device_id(),
    .output_word_format(), .active_channel(), .result_word());
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Next eligible channel above c, wrapping; none eligible gives 0
  function automatic logic [2:0] nxt(input logic [2:0] c, input logic [7:0] m);
    for (int k = 1; k <= 8; k++) if (m[3'(c + k)]) return 3'(c + k);
    return 3'h0;
  endfunction : nxt
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic [6:0] a, input logic w, input logic [7:0] d,
                     input logic [7:0] e);
    host.xfer(a, w, d, q);
    lf = lfsr(lf);
    chk(q, e);
  endtask : acc
  task automatic conv();
    cst = 1'b1;
    @(negedge clk);
    cst = 1'b0;
    repeat (2) @(negedge clk);
  endtask : conv
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // Random conversion data on every falling edge
  always @(negedge clk) begin
    res <= {lfsr(res[15:8]), lfsr(res[7:0])};
    rng <= res[2:0];
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      $display("ERROR %0t: timeout", $time);
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    acc(A_EN, 1'b0, lf, 8'hff);
    acc(A_PD, 1'b0, lf, 8'h00);
    chk(pd8, 8'h00);
    acc(A_FT, 1'b0, lf, 8'h00);
    acc(7'h04, 1'b0, lf, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], 3'h0, 3'(i)};
      acc(A_FT, 1'b1, v, v);
      acc(A_FT, 1'b0, lf, v);
      chk({dev, 3'h0, fmt}, v);
      repeat (20) @(negedge clk);
    end
    acc(A_EN, 1'b1, 8'h00, 8'h00);
    sel4 = 1'b1;
    acc(A_EN, 1'b0, lf, 8'hf0);
    acc(A_PD, 1'b1, 8'hff, 8'hff);
    chk(pd4, 8'h0f);
    sel4 = 1'b0;
    conv();
    mc = 3'h0;
    chk({5'h0, ach}, 8'h00);
    for (int j = 0; j < 12; j++) begin
      en = lf;
      pd = lfsr(lf) & ~(en & {8{j[0]}});
      acc(A_EN, 1'b1, en, en);
      acc(A_PD, 1'b1, pd, pd);
      chk(pd8, pd);
      repeat (6) begin
        mc = nxt(mc, en & ~pd);
        conv();
        chk({5'h0, ach}, {5'h0, mc});
      end
    end
    mch = lf[2:0];
    acc(A_PD, 1'b1, pd & ~(8'h01 << mch), pd & ~(8'h01 << mch));
    man = 1'b1;
    conv();
    chk({5'h0, ach}, {5'h0, mch});
    man = 1'b0;
    ce = 1'b0;
    repeat (5) @(negedge clk);
    ce = 1'b1;
    resetn = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    acc(A_EN, 1'b0, lf, 8'hff);
    chk(pd8, 8'h00);
    stop_test();
  end
endmodule : tb
